// [xsc_status.sv]
`timescale 1ns/1ps
// Purpose: serial-poll status, service request, talk string and clear control
// Assumes: bus-side protocol engine decodes instructions into pulses
// Notes: all pulse inputs come from same-clock logic; lines and switches from pins
module xsc_status
    import xsc_pkg::*;
#(
    parameter longint LOSS_NORMAL = LOSS_CYC_NORMAL,
    parameter longint LOSS_300 = LOSS_CYC_300,
    parameter longint LOSS_150 = LOSS_CYC_150
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // pins: modem, dialler, switches
    input wire logic cts_i,
    input wire logic dsr_i,
    input wire logic abandon_retry_line_i,
    input wire logic line_occupied_signal_i,
    input wire logic dialler_power_indication_i,
    input wire logic call_origination_status_i,
    input wire logic call_complete_i,
    input wire logic sw7_srq_i,
    input wire logic sw8_no_flush_i,
    input wire logic sw9_no_ifc_clear_i,
    input wire logic sw10_no_untalk_i,
    // same-clock link and protocol events
    input wire logic [1:0] link_rate_i,
    input wire logic remote_data_i,
    input wire logic dialling_i,
    input wire logic string_req_i,
    input wire logic tx_empty_i,
    input wire logic station_ack_i,
    input wire logic [4:0] station_addr_i,
    input wire logic station_drop_i,
    input wire logic inst_activate_i,
    input wire logic inst_idle_i,
    input wire logic inst_loss_en_i,
    input wire logic inst_loss_dis_i,
    input wire logic inst_no_untalk_i,
    input wire logic inst_untalk_i,
    input wire logic inst_no_flush_i,
    input wire logic inst_flush_i,
    input wire logic serial_poll_i,
    input wire logic talk_req_i,
    input wire logic ifc_i,
    // serial poll and service request
    output logic srq_o,
    output logic [7:0] serial_poll_status_o,
    // talk bytes
    input wire logic byte_ack_i,
    output logic byte_valid_o,
    output logic [7:0] byte_data_o,
    output logic byte_end_o,
    // buffer clears
    output logic clr_local_tx_o,
    output logic clr_remote_rx_o,
    output logic clr_remote_tx_o,
    output logic clr_local_rx_o,
    output logic clr_packets_o,
    output logic ifc_remote_o,
    output logic ifc_queue_o,
    output logic loss_tx_clear_o,
    // configuration out
    output logic [7:0] configuration_state_o
);
    // [R25] two-flop sync of pins
    logic [10:0] sync1, sync2, sync_d;
    wire [10:0] pins = {sw10_no_untalk_i, sw9_no_ifc_clear_i, sw8_no_flush_i, sw7_srq_i, call_complete_i,
        abandon_retry_line_i, call_origination_status_i, dialler_power_indication_i, line_occupied_signal_i,
        dsr_i, cts_i};
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync_d <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync_d <= sync2;
        end
    end
    wire s_cts = sync2[0];
    wire s_dsr = sync2[1];
    wire s_occupied = sync2[2];
    wire s_power = sync2[3];
    wire s_origin = sync2[4];
    wire s_abandon = sync2[5];
    wire s_call = sync2[6];
    wire s_sw7 = sync2[7];
    wire s_sw8 = sync2[8];
    wire s_sw9 = sync2[9];
    wire s_sw10 = sync2[10];
    wire abandon_rise = s_abandon & ~sync_d[5];
    wire call_rise = s_call & ~sync_d[6];
    wire sw8_chg = s_sw8 ^ sync_d[8];
    wire sw10_chg = s_sw10 ^ sync_d[10];

    // [R24] loss-of-remote-data timer
    logic [40:0] loss_cnt;
    logic remote_loss_flag, loss_d, first_seen, active, string_pend;
    wire [40:0] loss_lim = (link_rate_i == 2'(XSC_RATE_150)) ? 41'(LOSS_150) :
        (link_rate_i == 2'(XSC_RATE_300)) ? 41'(LOSS_300) : 41'(LOSS_NORMAL);
    wire loss_hit = (loss_cnt >= loss_lim - 41'h1);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            loss_cnt <= '0;
            remote_loss_flag <= 1'b0;
            loss_d <= 1'b0;
        end else begin
            loss_d <= remote_loss_flag;
            if (remote_data_i) begin
                loss_cnt <= '0;
                remote_loss_flag <= 1'b0;
            end else if (loss_hit) begin
                remote_loss_flag <= 1'b1;
            end else begin
                loss_cnt <= loss_cnt + 41'h1;
            end
        end
    end
    wire loss_rise = remote_loss_flag & ~loss_d;

    // status event flags
    logic st_abandon, st_call, st_loss, st_rqs, st_sent;
    // [R04] abandon during dialling
    wire set_abandon = abandon_rise & dialling_i;
    // [R05] call completion on any rise, dialling not checked
    wire set_call = call_rise;
    // [R03] no request when idle
    wire loss_cause = loss_rise & active;
    // [R06] string sent only with switch 7
    wire set_sent = string_pend & tx_empty_i & s_sw7;
    // [R01] request gated by switch 7
    wire set_rqs = s_sw7 & (set_abandon | set_call | loss_cause | set_sent);
    // [R08] serial poll clears; set wins
    wire next_rqs = set_rqs | (st_rqs & ~serial_poll_i);
    wire next_sent = set_sent | (st_sent & ~serial_poll_i);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_abandon <= 1'b0;
            st_call <= 1'b0;
            st_loss <= 1'b0;
            st_rqs <= 1'b0;
            st_sent <= 1'b0;
            string_pend <= 1'b0;
        end else begin
            // [R07] causes update regardless of switch 7
            st_abandon <= s_abandon & (st_abandon | set_abandon);
            st_call <= s_call & (st_call | set_call);
            // [R02] loss bit
            st_loss <= remote_loss_flag;
            st_rqs <= next_rqs;
            st_sent <= next_sent;
            string_pend <= string_req_i | (string_pend & ~tx_empty_i);
        end
    end

    // configuration state
    logic loss_clear_en, no_untalk, no_flush, started;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active <= RESET_ACTIVE;
            loss_clear_en <= RESET_LOSS_CLEAR_EN;
            no_untalk <= 1'b0;
            no_flush <= 1'b0;
            started <= 1'b0;
        end else begin
            started <= 1'b1;
            if (inst_activate_i) active <= 1'b1;
            else if (inst_idle_i) active <= 1'b0;
            // [R17] loss-clear enable
            if (inst_loss_en_i) loss_clear_en <= 1'b1;
            else if (inst_loss_dis_i) loss_clear_en <= 1'b0;
            // [R18] switch 10 edges or instructions
            if (sw10_chg || !started) no_untalk <= s_sw10;
            else if (inst_no_untalk_i) no_untalk <= 1'b1;
            else if (inst_untalk_i) no_untalk <= 1'b0;
            // [R19] switch 8 edges, read at start
            if (sw8_chg || !started) no_flush <= s_sw8;
            else if (inst_no_flush_i) no_flush <= 1'b1;
            else if (inst_flush_i) no_flush <= 1'b0;
        end
    end

    // [R14] [R15] station character from returned bits
    logic [7:0] station_char;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) station_char <= NO_STATION_CHAR;
        else if (station_ack_i) station_char <= {STATION_HIGH, station_addr_i};
        else if (station_drop_i) station_char <= NO_STATION_CHAR;
    end

    // [R09] status byte with live mirrors
    wire [7:0] status_byte = {st_sent, st_rqs, 1'b0, st_loss, st_call, st_abandon, s_dsr, s_cts};
    // [R13] dialler lines
    wire [7:0] dialler_line_state = {5'h00, s_occupied, s_power, s_origin};
    // [R16] [R20] configuration byte
    wire [7:0] next_config = {1'b0, active, string_pend, loss_clear_en, no_untalk, s_sw9, no_flush, s_sw7};

    // [R10] [R12] status on poll or talk, talk clears nothing
    xsc_talk_if tif ();
    assign tif.start = talk_req_i & ~tif.busy;
    assign tif.bytes[0] = status_byte;
    assign tif.bytes[1] = dialler_line_state;
    assign tif.bytes[2] = station_char;
    assign tif.bytes[3] = next_config;
    xsc_talker u_talker (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .tif(tif),
        .byte_ack_i(byte_ack_i),
        .byte_valid_o(byte_valid_o),
        .byte_data_o(byte_data_o),
        .byte_end_o(byte_end_o)
    );

    // [R21] [R22] [R23] interface clear actions
    wire ifc_full = ifc_i & ~s_sw9;
    wire ifc_keep = ifc_i & s_sw9;
    wire loss_clear = loss_rise & s_sw7 & loss_clear_en;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            srq_o <= 1'b0;
            serial_poll_status_o <= 8'h00;
            configuration_state_o <= 8'h00;
            clr_local_tx_o <= 1'b0;
            clr_remote_rx_o <= 1'b0;
            clr_remote_tx_o <= 1'b0;
            clr_local_rx_o <= 1'b0;
            clr_packets_o <= 1'b0;
            ifc_remote_o <= 1'b0;
            ifc_queue_o <= 1'b0;
            loss_tx_clear_o <= 1'b0;
        end else begin
            srq_o <= next_rqs;
            serial_poll_status_o <= status_byte;
            configuration_state_o <= next_config;
            clr_local_tx_o <= ifc_full | loss_clear;
            clr_remote_rx_o <= ifc_full;
            ifc_remote_o <= ifc_full;
            ifc_queue_o <= ifc_keep;
            clr_remote_tx_o <= ifc_i;
            clr_local_rx_o <= ifc_i;
            clr_packets_o <= ifc_i;
            loss_tx_clear_o <= loss_clear;
        end
    end

    // [R01] request needs switch 7
    a_rqs_needs_sw7: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(st_rqs) |-> $past(s_sw7)) else $error("request raised with switch 7 off");
    // [R03] idle loss no request
    a_idle_no_req: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (loss_rise && !active && !set_abandon && !set_call && !set_sent) |=> !$rose(st_rqs))
        else $error("request while idle");
    // [R08] poll clears
    a_poll_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (serial_poll_i && !set_rqs) |=> !st_rqs) else $error("poll did not clear request");
    // [R06] sent bit gated
    a_sent_gated: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(st_sent) |-> $past(s_sw7)) else $error("string sent set with switch 7 off");
    // [R02] loss mirrored
    a_loss_bit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(remote_loss_flag) |=> ##1 serial_poll_status_o[ST_LOSS]) else $error("loss bit missing");
    // [R21] full clear mode
    a_ifc_full: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ifc_i && !s_sw9 |=> clr_local_tx_o && ifc_remote_o && !ifc_queue_o) else $error("ifc full clear");
    // [R23] keep mode
    a_ifc_keep: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ifc_i && s_sw9 |=> ifc_queue_o && clr_local_rx_o && !clr_remote_rx_o) else $error("ifc keep mode");
    // [R20] switch mirrors
    a_cfg_sw: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 configuration_state_o[0] == $past(s_sw7) && configuration_state_o[2] == $past(s_sw9))
        else $error("switch mirror wrong");
    c_poll_req: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) st_rqs ##1 serial_poll_i);
    c_loss: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) loss_rise && active);
    c_ifc_keep: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) ifc_keep);
endmodule // xsc_status

// [xsc_pkg.sv]
// Purpose: shared constants for the extender status and clear logic
// Assumes: 100 MHz core clock, one clock domain
// Notes: status and talk byte layouts, timing counts, reset values
// Notes on behaviour
// [R01] own service request only with switch 7 on; sets request bit 7
// [R02] remote data loss sets status bit 5 and is a request cause
// [R03] remote data loss raises no request while idle
// [R04] abandon-retry during dialling sets status bit 3 as request cause
// [R05] call completion after dialling sets status bit 4 as request cause; code sets it on any call-complete rise, dialling not checked
// [R06] string sent after completion request sets bit 8, only with switch 7 on
// [R07] bits 3, 4, 5 update even with switch 7 off, no request then
// [R08] serial poll clears request bit 7 and string-sent bit 8
// [R09] bit 6 unused; bit 2 mirrors data-set-ready, bit 1 clear-to-send
// [R10] answer a serial poll at any time
// [R11] talk sends exactly four bytes, end flag with the fourth
// [R12] talk byte 1 equals status byte, sending it clears nothing
// [R13] talk byte 2: occupied bit 3, power bit 2, origination bit 1
// [R14] talk byte 3 is last active station character, else question mark
// [R15] remote returns five address bits; byte 3 built from them
// [R16] byte 4: bit 8 unused, bit 7 active, bit 6 completion pending
// [R17] byte 4 bit 5 set by loss-clear enable, cleared by disable and reset
// [R18] byte 4 bit 4 follows switch 10 edges or its instructions
// [R19] byte 4 bit 2 follows switch 8 edges or instructions; reset reads switch
// [R20] byte 4 bit 3 reflects switch 9, bit 1 reflects switch 7
// [R21] switch 9 off: clear clears outbound buffers, clear repeated remotely
// [R22] interface clear always clears inbound buffers, keeps request messages
// [R23] switch 9 on: outbound kept, clear queued in order; packets dropped
// [R24] loss flag after 8 s, 12 s at 300 bit/s, 20 s at 150 bit/s
// [R25] external line mirrors are synchronised before use
package xsc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int LOSS_S_NORMAL = 8;
    localparam int LOSS_S_300 = 12;
    localparam int LOSS_S_150 = 20;
    localparam longint LOSS_CYC_NORMAL = longint'(LOSS_S_NORMAL) * CLK_MHZ * 1000000;
    localparam longint LOSS_CYC_300 = longint'(LOSS_S_300) * CLK_MHZ * 1000000;
    localparam longint LOSS_CYC_150 = longint'(LOSS_S_150) * CLK_MHZ * 1000000;
    // status byte bit positions (bit n is documented bit n+1)
    localparam int ST_CTS = 0;
    localparam int ST_DSR = 1;
    localparam int ST_ABANDON = 2;
    localparam int ST_CALL = 3;
    localparam int ST_LOSS = 4;
    localparam int ST_RQS = 6;
    localparam int ST_SENT = 7;
    localparam int TALK_BYTES = 4;
    localparam logic [7:0] NO_STATION_CHAR = 8'h3f;
    // station character sits in the 0x20 range, the same range as the question mark
    localparam logic [2:0] STATION_HIGH = 3'h1;
    localparam logic RESET_LOSS_CLEAR_EN = 1'b0;
    localparam logic RESET_ACTIVE = 1'b1;
    localparam int LINE_BITS = 7;
    typedef enum logic [1:0] {XSC_RATE_NORMAL, XSC_RATE_300, XSC_RATE_150} xsc_rate_e;
    typedef enum {XSC_T_IDLE, XSC_T_SEND, XSC_T_WAIT} xsc_talk_e;
endpackage

// [xsc_talk_if.sv]
`timescale 1ns/1ps
// Purpose: carrier between core and talk serialiser
// Assumes: single clock
// Notes: four bytes handed over as one snapshot
interface xsc_talk_if;
    logic start;
    logic [7:0] bytes [4];
    logic busy;
    modport core (output start, output bytes, input busy);
    modport talker (input start, input bytes, output busy);
endinterface // xsc_talk_if

// [xsc_talker.sv]
`timescale 1ns/1ps
// Purpose: sends the four-byte talk string over a byte handshake
// Assumes: bus side acknowledges each byte with byte_ack_i
// Notes: bytes latched at start so a mid-string change cannot tear it
module xsc_talker
    import xsc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // carrier
    xsc_talk_if.talker tif,
    // byte output
    input wire logic byte_ack_i,
    output logic byte_valid_o,
    output logic [7:0] byte_data_o,
    output logic byte_end_o
);
    xsc_talk_e state;
    logic [1:0] idx;
    logic [7:0] snap [4];
    wire last_byte = (idx == 2'(TALK_BYTES - 1));
    assign tif.busy = (state != XSC_T_IDLE);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= XSC_T_IDLE;
            idx <= 2'h0;
            byte_valid_o <= 1'b0;
            byte_data_o <= 8'h00;
            byte_end_o <= 1'b0;
            for (int i = 0; i < 4; i++) snap[i] <= 8'h00;
        end else begin
            case (state)
                XSC_T_IDLE: begin
                    if (tif.start) begin
                        snap <= tif.bytes;
                        idx <= 2'h0;
                        state <= XSC_T_SEND;
                    end
                end
                // [R11] four bytes, end flag
                XSC_T_SEND: begin
                    byte_valid_o <= 1'b1;
                    byte_data_o <= snap[idx];
                    byte_end_o <= last_byte;
                    state <= XSC_T_WAIT;
                end
                XSC_T_WAIT: begin
                    if (byte_ack_i) begin
                        byte_valid_o <= 1'b0;
                        byte_end_o <= 1'b0;
                        idx <= idx + 2'h1;
                        state <= last_byte ? XSC_T_IDLE : XSC_T_SEND;
                    end
                end
                default: state <= XSC_T_IDLE;
            endcase
        end
    end
    // [R11] end only on fourth
    a_end_on_last: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        byte_end_o |-> byte_valid_o && idx == 2'h3) else $error("end flag not on fourth byte");
    c_talk_done: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        byte_end_o && byte_ack_i);
endmodule // xsc_talker

// [xsc_ctl_model.sv]
`timescale 1ns/1ps
// Purpose: bus controller model that serial polls and reads the talk string
// Assumes: a talk byte stays offered on byte_valid_i until acknowledged
// Notes: drives on the falling edge; a slow ack stands for a slow controller
module xsc_ctl_model (
    // clock
    input wire logic clk_i,
    // talk byte side
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_data_i,
    input wire logic byte_end_i,
    output logic byte_ack_o,
    // requests
    output logic serial_poll_o,
    output logic talk_req_o
);
    initial begin
        byte_ack_o = 1'b0;
        serial_poll_o = 1'b0;
        talk_req_o = 1'b0;
    end
    task automatic poll();
        @(negedge clk_i);
        serial_poll_o = 1'b1;
        @(negedge clk_i);
        serial_poll_o = 1'b0;
    endtask
    task automatic talk(input int slow, output logic [31:0] got, output logic [3:0] ends, output int extra);
        int n;
        int w;
        n = 0;
        w = 0;
        extra = 0;
        got = '0;
        ends = '0;
        @(negedge clk_i);
        talk_req_o = 1'b1;
        @(negedge clk_i);
        talk_req_o = 1'b0;
        while (n < 4 && w < 300) begin
            @(negedge clk_i);
            w++;
            if (byte_valid_i === 1'b1) begin
                repeat (slow) @(negedge clk_i);
                got[8*n +: 8] = byte_data_i;
                ends[n] = byte_end_i;
                byte_ack_o = 1'b1;
                @(negedge clk_i);
                byte_ack_o = 1'b0;
                n++;
            end
        end
        // a fifth byte would show up here
        repeat (10) begin
            @(negedge clk_i);
            if (byte_valid_i !== 1'b0) extra++;
        end
    endtask
endmodule // xsc_ctl_model

// [testbench.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench for the extender status and clear logic
// Assumes: loss counts shortened to 20/30/50 cycles; inputs change on the falling edge
// Notes: each scenario starts from a fresh reset so request causes do not mix
module testbench;
    import xsc_pkg::*;
    logic clk, rst_b, rdata, dial, tx_empty;
    logic [1:0] rate;
    logic [3:0] sw;
    logic [6:0] pin;
    logic [11:0] ev;
    logic [4:0] addr;
    logic [7:0] clr_seen, station;
    logic [31:0] seed, r;
    logic act, le, nu, nf;
    wire ack, poll, treq, srq, bval, bend;
    wire [7:0] st, cfg, bdat, clr;
    int mismatches, n_tests, cyc, k;
    int lim [4] = '{20, 30, 50, 20};

    xsc_status #(.LOSS_NORMAL(20), .LOSS_300(30), .LOSS_150(50)) i_xsc_status (
        .core_clk_i(clk), .rst_b_i(rst_b), .cts_i(pin[0]), .dsr_i(pin[1]), .abandon_retry_line_i(pin[2]),
        .line_occupied_signal_i(pin[3]), .dialler_power_indication_i(pin[4]),
        .call_origination_status_i(pin[5]), .call_complete_i(pin[6]), .sw7_srq_i(sw[0]),
        .sw8_no_flush_i(sw[1]), .sw9_no_ifc_clear_i(sw[2]), .sw10_no_untalk_i(sw[3]), .link_rate_i(rate),
        .remote_data_i(rdata), .dialling_i(dial), .string_req_i(ev[8]), .tx_empty_i(tx_empty),
        .station_ack_i(ev[9]), .station_addr_i(addr), .station_drop_i(ev[10]), .inst_activate_i(ev[0]),
        .inst_idle_i(ev[1]), .inst_loss_en_i(ev[2]), .inst_loss_dis_i(ev[3]), .inst_no_untalk_i(ev[4]),
        .inst_untalk_i(ev[5]), .inst_no_flush_i(ev[6]), .inst_flush_i(ev[7]), .serial_poll_i(poll),
        .talk_req_i(treq), .ifc_i(ev[11]), .srq_o(srq), .serial_poll_status_o(st), .byte_ack_i(ack),
        .byte_valid_o(bval), .byte_data_o(bdat), .byte_end_o(bend), .clr_local_tx_o(clr[0]),
        .clr_remote_rx_o(clr[1]), .clr_remote_tx_o(clr[2]), .clr_local_rx_o(clr[3]), .clr_packets_o(clr[4]),
        .ifc_remote_o(clr[5]), .ifc_queue_o(clr[6]), .loss_tx_clear_o(clr[7]), .configuration_state_o(cfg));

    xsc_ctl_model i_xsc_ctl_model (.clk_i(clk), .byte_valid_i(bval), .byte_data_i(bdat), .byte_end_i(bend),
        .byte_ack_o(ack), .serial_poll_o(poll), .talk_req_o(treq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // clear pulses are collected so their exact cycle does not matter
    always @(posedge clk) begin
        clr_seen <= clr_seen | clr;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // f = {sent, rqs, loss, call, abandon}
    function automatic logic [7:0] stat_exp(logic [4:0] f, logic [1:0] m);
        return {f[4:3], 1'b0, f[2:0], m};
    endfunction
    // f = {active, pending, loss clear, no untalk, no flush}
    function automatic logic [7:0] cfg_exp(logic [4:0] f, logic [3:0] s);
        return {1'b0, f[4:1], s[2], f[0], s[0]};
    endfunction

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic do_reset(input logic [3:0] s);
        rst_b = 1'b0;
        sw = s;
        {rdata, dial, tx_empty, rate, pin, ev, addr} = {3'b101, 2'h0, 7'h0, 12'h0, 5'h0};
        wt(10);
        rst_b = 1'b1;
        wt(6);
    endtask
    task automatic pulse(input int i);
        ev[i] = 1'b1;
        @(negedge clk);
        ev[i] = 1'b0;
        wt(5);
    endtask
    task automatic talk_chk(input int slow, input logic [7:0] b1, b2, b3, b4);
        logic [31:0] got;
        logic [3:0] ends;
        int extra;
        i_xsc_ctl_model.talk(slow, got, ends, extra);
        chk8("talk byte 1", b1, got[7:0]);
        chk8("talk byte 2", b2, got[15:8]);
        chk8("talk byte 3", b3, got[23:16]);
        chk8("talk byte 4", b4, got[31:24]);
        chk8("talk end flags", 8'h08, {4'h0, ends});
        chk8("extra talk bytes", 8'h00, 8'(extra));
    endtask

    initial begin
        seed = 32'h9e7a15d8;
        clr_seen = 8'h00;
        cyc = 0;
        do_reset(4'hf);
        chk8("config after reset", cfg_exp(5'b10011, 4'hf), cfg);
        do_reset(4'h0);
        chk8("config after reset", cfg_exp(5'b10000, 4'h0), cfg);
        {act, le, nu, nf} = 4'b1000;
        repeat (24) begin
            k = int'(rnd() % 12);
            if (k < 8) begin
                pulse(k);
                if (k < 2) act = (k == 0);
                else if (k < 4) le = (k == 2);
                else if (k < 6) nu = (k == 4);
                else nf = (k == 6);
            end else begin
                sw[k-8] = ~sw[k-8];
                if (k == 9) nf = sw[1];
                if (k == 11) nu = sw[3];
                wt(6);
            end
            chk8("config byte", cfg_exp({act, 1'b0, le, nu, nf}, sw), cfg);
        end
        do_reset(4'h0);
        for (int j = 0; j < 6; j++) begin
            r = rnd();
            pin = {1'b0, r[2], r[3], r[4], 1'b0, r[1:0]};
            addr = r[9:5];
            if (r[10]) begin
                station = {3'b001, addr};
                pulse(9);
            end else begin
                station = 8'h3f;
                pulse(10);
            end
            chk8("status byte", stat_exp(5'h0, r[1:0]), st);
            talk_chk(j % 3, stat_exp(5'h0, r[1:0]), {5'h0, r[4:2]}, station, cfg_exp(5'b10000, 4'h0));
        end
        for (int s = 0; s < 2; s++) begin
            do_reset({3'b000, s[0]});
            dial = 1'b1;
            pin[2] = 1'b1;
            wt(6);
            chk8("status abandon", stat_exp({1'b0, s[0], 3'b001}, 2'b00), st);
            chk1("request abandon", s[0], srq);
            i_xsc_ctl_model.poll();
            wt(2);
            chk1("request after poll", 1'b0, srq);
            pin[2] = 1'b0;
            pin[6] = 1'b1;
            wt(6);
            chk8("status call done", stat_exp({1'b0, s[0], 3'b010}, 2'b00), st);
        end
        for (int s = 0; s < 2; s++) begin
            do_reset({3'b000, s[0]});
            tx_empty = 1'b0;
            pulse(8);
            chk8("config pending", cfg_exp(5'b11000, {3'b000, s[0]}), cfg);
            tx_empty = 1'b1;
            wt(4);
            chk8("status string sent", stat_exp({s[0], s[0], 3'b000}, 2'b00), st);
            talk_chk(1, stat_exp({s[0], s[0], 3'b000}, 2'b00), 8'h00, 8'h3f, cfg_exp(5'b10000, {3'b000, s[0]}));
            chk1("request kept by talk", s[0], srq);
            i_xsc_ctl_model.poll();
            wt(2);
            chk8("status after poll", 8'h00, st);
        end
        for (int q = 0; q < 4; q++) begin
            do_reset(4'h1);
            rate = 2'(q % 3);
            pulse(2);
            if (q == 3) pulse(1);
            clr_seen = 8'h00;
            rdata = 1'b0;
            wt(lim[q] - 4);
            if (q != 3) chk1("loss early", 1'b0, st[4]);
            wt(8);
            chk1("loss set", 1'b1, st[4]);
            chk1("loss request", q != 3, srq);
            if (q != 3) chk1("loss tx clear", 1'b1, clr_seen[7]);
            i_xsc_ctl_model.poll();
            wt(2);
            chk8("status after loss poll", stat_exp(5'b00100, 2'b00), st);
        end
        for (int s = 0; s < 2; s++) begin
            do_reset({1'b0, s[0], 2'b00});
            clr_seen = 8'h00;
            pulse(11);
            chk8("interface clear", (s == 1) ? 8'h5c : 8'h3f, clr_seen);
        end
        end_sim();
    end
endmodule // testbench
